// [cacf_pkg.sv]
/*
  constants shared by the counter array control logic: register offsets,
  field positions, widths and reset values.
  assumes an 8-bit register bus with byte-wide offsets.
*/
package cacf_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NMOD   = 5;
  localparam int CNT_W  = 16;
  localparam int REG_W  = 8;
  localparam int ADDR_W = 8;
  localparam int ST_W   = 6;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CONTROL     = 8'hD8;
  localparam logic [ADDR_W-1:0] OFF_MODE_CTL    = 8'hD9;
  localparam logic [ADDR_W-1:0] OFF_MODULE_MODE = 8'hDA;
  localparam logic [ADDR_W-1:0] OFF_CAP_LO      = 8'hEA;
  localparam logic [ADDR_W-1:0] OFF_CAP_HI      = 8'hFA;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS  = 8'hE0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR   = 8'hE1;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE  = 8'hE2;

  // ----------------------------------------------------------------
  // counter control and counter mode fields
  // ----------------------------------------------------------------
  localparam int CTL_ROLLOVER = 7;
  localparam int CTL_RUN      = 6;
  localparam int CM_ROLL_IRQ  = 0;
  localparam int CM_WDOG      = 6;
  localparam logic [REG_W-1:0] CM_MASK = 8'hC7;

  // ----------------------------------------------------------------
  // module mode fields
  // ----------------------------------------------------------------
  localparam int MM_IRQ_EN = 0;
  localparam int MM_PWM    = 1;
  localparam int MM_INVERT = 2;
  localparam int MM_MATCH  = 3;
  localparam int MM_FALL   = 4;
  localparam int MM_RISE   = 5;
  localparam int MM_CMP    = 6;
  localparam int MM_W      = 7;
  localparam int WDOG_MOD  = 4;
  localparam int ST_ROLL   = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hFFFF;
  localparam logic [ST_W-1:0]  ST_RESET  = 6'h00;

endpackage

// [cacf_ch_if.sv]
/*
  per-module link between the control block and one compare/capture
  module. assumes both ends sit on core_clk.
*/
`timescale 1ns/10ps
interface cacf_ch_if;
  import cacf_pkg::*;
  logic [REG_W-1:0] mode;
  logic             wr_lo;
  logic             wr_hi;
  logic [REG_W-1:0] wdata;
  logic [CNT_W-1:0] count;
  logic             count_adv;
  logic [CNT_W-1:0] cap_val;
  logic             event_hit;
  logic             hit;
  logic             pin_out;
  logic             pin_oe;

  modport ctl (output mode, wr_lo, wr_hi, wdata, count, count_adv,
               input cap_val, event_hit, hit, pin_out, pin_oe);
  modport chan (input mode, wr_lo, wr_hi, wdata, count, count_adv,
                output cap_val, event_hit, hit, pin_out, pin_oe);
endinterface

// [cacf_channel.sv]
/*
  one compare/capture module: pin synchroniser, edge capture, comparator,
  output inversion and pwm output.
  assumes pin_in is asynchronous and rst_b is already synchronised.
*/
`timescale 1ns/10ps
module cacf_channel (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pin
  input  wire logic pin_in,
  // control side
  cacf_ch_if.chan   ch
);
  import cacf_pkg::*;

  logic             pin_meta;
  logic             pin_sync;
  logic             pin_prev;
  logic [CNT_W-1:0] cap;
  logic             rise;
  logic             fall;
  logic             capture;
  logic             hit;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // pins idle high behind their pull-ups; a low reset would fake a rise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign rise    = pin_sync & ~pin_prev;
  assign fall    = ~pin_sync & pin_prev;
  assign capture = (rise & ch.mode[MM_RISE])
                 | (fall & ch.mode[MM_FALL]);  // see R14
  // one hit per counter value, only while it advances
  assign hit = ch.mode[MM_CMP] & ch.count_adv
             & (ch.count == cap);  // see R15
  assign ch.cap_val = cap;

  // ----------------------------------------------------------------
  // compare/capture value; a capture wins over a software write
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap <= CNT_RESET;
    end else if (capture) begin
      cap <= ch.count;  // see R17
    end else if (ch.wr_lo) begin
      cap[REG_W-1:0] <= ch.wdata;
    end else if (ch.wr_hi) begin
      cap[CNT_W-1:REG_W] <= ch.wdata;
    end
  end

  // ----------------------------------------------------------------
  // events and pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ch.event_hit <= 1'b0;
      ch.hit       <= 1'b0;
    end else begin
      ch.event_hit <= capture | (hit & ch.mode[MM_MATCH]);  // see R13
      ch.hit       <= hit;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ch.pin_out <= 1'b0;
      ch.pin_oe  <= 1'b0;
    end else begin
      ch.pin_oe <= ch.mode[MM_PWM] | ch.mode[MM_INVERT];
      if (ch.mode[MM_PWM]) begin
        ch.pin_out <= (ch.count[REG_W-1:0] >= cap[REG_W-1:0]);  // see R11
      end else if (hit & ch.mode[MM_INVERT]) begin
        ch.pin_out <= ~ch.pin_out;  // see R12
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_toggle_on_hit: assert property (  // see R12
    @(posedge clk) disable iff (!rst_b)
    (hit && ch.mode[MM_INVERT] && !ch.mode[MM_PWM])
      |=> (ch.pin_out != $past(ch.pin_out)))
    else $error("pin did not invert on compare hit");
  a_match_sets_event: assert property (  // see R13
    @(posedge clk) disable iff (!rst_b)
    (hit && ch.mode[MM_MATCH]) |=> ch.event_hit)
    else $error("compare hit did not raise module event");
  a_capture_loads: assert property (  // see R17
    @(posedge clk) disable iff (!rst_b)
    capture |=> (cap == $past(ch.count)) && ch.event_hit)
    else $error("capture did not load counter value");
  a_cmp_needs_enable: assert property (  // see R15
    @(posedge clk) disable iff (!rst_b)
    (!ch.mode[MM_CMP] && !capture) |=> !ch.event_hit)
    else $error("event without comparator or capture");
  c_capture_both: cover property (@(posedge clk) disable iff (!rst_b)
    capture && ch.mode[MM_RISE] && ch.mode[MM_FALL]);
  c_toggle: cover property (@(posedge clk) disable iff (!rst_b)
    hit && ch.mode[MM_INVERT]);
endmodule

// [cacf_top.sv]
/*
  control, flag and mode logic of a five-module counter array: shared
  16-bit counter, control and mode registers, flags and interrupt request.
  assumes count_tick is a one-cycle pulse from the count source on
  core_clk, and a bus master that reads data one cycle after rd.
*/
`timescale 1ns/10ps
// How it works
// R1: counter wrapping past its maximum sets the rollover flag, bit 7.
// R2: rollover flag requests an interrupt only while its enable is set.
// R3: rollover flag set by hardware or software, cleared only by software.
// R4: counter advances only while run control, bit 6, is one.
// R5: a match or capture sets that module's event flag, bits 0 to 4.
// R6: module event flags stay set until software clears them.
// R7: counter control reads zero after reset; bit 5 always reads as zero.
// R8: every module does edge capture, software timer, fast output, pwm.
// R9: module 4 can also act as a watchdog.
// R10: mode bit 0 lets the module's event flag reach the interrupt.
// R11: mode bit 1 turns the module pin into a pwm output.
// R12: mode bit 2 inverts the module pin on every compare hit while mode bit 1 is clear.
// R13: mode bit 3 sets the event flag on every compare hit.
// R14: mode bit 4 captures on falling, bit 5 on rising edges.
// R15: mode bit 6 enables the module's comparator.
// R16: all module events and rollover share one interrupt request.
// R17: capture loads the counter value into the module data pair.
// R18: control bit 5 and mode bit 7 do nothing and read as zero.
module cacf_top (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  // register port
  input  wire logic [cacf_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [cacf_pkg::REG_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [cacf_pkg::REG_W-1:0]    reg_rdata,
  // count source
  input  wire logic                          count_tick,
  // module pins
  input  wire logic [cacf_pkg::NMOD-1:0]     module_io_pin_in,
  output logic      [cacf_pkg::NMOD-1:0]     module_io_pin_out,
  output logic      [cacf_pkg::NMOD-1:0]     module_io_pin_oe,
  // interrupts and watchdog
  output logic                               irq_req,
  output logic                               intr,
  output logic                               watchdog_reset
);
  import cacf_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count;
  logic             count_adv;
  logic             wrap;
  logic             rollover_flag;
  logic             run_control;
  logic [NMOD-1:0]  module_event_flag;
  logic [REG_W-1:0] counter_mode_reg;
  logic [MM_W-1:0]  module_mode_reg [NMOD];
  logic [ST_W-1:0]  irq_status;
  logic [ST_W-1:0]  irq_enable;
  logic [NMOD-1:0]  ev_vec;
  logic [NMOD-1:0]  hit_vec;
  logic [NMOD-1:0]  irq_en_vec;
  logic [NMOD-1:0]  mode_wr;
  logic [NMOD-1:0]  lo_wr;
  logic [NMOD-1:0]  hi_wr;
  logic             ctl_wr;
  logic             next_irq_req;
  logic [REG_W-1:0] next_rdata;

  cacf_ch_if ch [NMOD] ();

  assign count_adv = run_control & count_tick;  // see R4
  assign wrap      = count_adv & (count == CNT_MAX);
  assign ctl_wr    = reg_wr & (reg_addr == OFF_CONTROL);

  // ----------------------------------------------------------------
  // modules
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NMOD; gi++) begin : g_mod
      assign mode_wr[gi] = reg_wr
        & (reg_addr == OFF_MODULE_MODE + ADDR_W'(gi));
      assign lo_wr[gi] = reg_wr & (reg_addr == OFF_CAP_LO + ADDR_W'(gi));
      assign hi_wr[gi] = reg_wr & (reg_addr == OFF_CAP_HI + ADDR_W'(gi));
      assign ch[gi].mode      = {1'b0, module_mode_reg[gi]};
      assign ch[gi].wr_lo     = lo_wr[gi];
      assign ch[gi].wr_hi     = hi_wr[gi];
      assign ch[gi].wdata     = reg_wdata;
      assign ch[gi].count     = count;
      assign ch[gi].count_adv = count_adv;
      assign ev_vec[gi]       = ch[gi].event_hit;
      assign hit_vec[gi]      = ch[gi].hit;
      assign irq_en_vec[gi]   = module_mode_reg[gi][MM_IRQ_EN];
      assign module_io_pin_out[gi] = ch[gi].pin_out;
      assign module_io_pin_oe[gi]  = ch[gi].pin_oe;

      // every module carries the full capture/compare/pwm set
      cacf_channel u_chan (  // see R8
        .clk    (core_clk),
        .rst_b  (rst_sync_b),
        .pin_in (module_io_pin_in[gi]),
        .ch     (ch[gi])
      );

      // mode bit 7 is not stored at all
      always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          module_mode_reg[gi] <= REG_RESET[MM_W-1:0];
        end else if (mode_wr[gi]) begin
          module_mode_reg[gi] <= reg_wdata[MM_W-1:0];  // see R18
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // shared counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count <= CNT_RESET;
    end else if (count_adv) begin
      count <= count + 16'h0001;  // see R4
    end
  end

  // ----------------------------------------------------------------
  // counter control: run, rollover and module flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      run_control <= REG_RESET[CTL_RUN];  // see R7
    end else if (ctl_wr) begin
      run_control <= reg_wdata[CTL_RUN];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rollover_flag <= REG_RESET[CTL_ROLLOVER];
    end else if (ctl_wr) begin
      rollover_flag <= reg_wdata[CTL_ROLLOVER] | wrap;  // see R3
    end else if (wrap) begin
      rollover_flag <= 1'b1;  // see R1
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      module_event_flag <= REG_RESET[NMOD-1:0];
    end else if (ctl_wr) begin
      module_event_flag <= reg_wdata[NMOD-1:0] | ev_vec;  // see R6
    end else begin
      module_event_flag <= module_event_flag | ev_vec;  // see R5
    end
  end

  // counter mode: stores the documented bits only
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      counter_mode_reg <= REG_RESET;
    end else if (reg_wr && reg_addr == OFF_MODE_CTL) begin
      counter_mode_reg <= reg_wdata & CM_MASK;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request and watchdog
  // ----------------------------------------------------------------
  assign next_irq_req =
      (rollover_flag & counter_mode_reg[CM_ROLL_IRQ])  // see R2
    | (|(module_event_flag & irq_en_vec));  // see R10 see R16

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= next_irq_req;
    end
  end

  // the watchdog times on the shared counter; this flags module 4's compare hit as its expiry while counter mode bit 6 and module 4's mode bit 3 are both set
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= counter_mode_reg[CM_WDOG] & hit_vec[WDOG_MOD]
        & module_mode_reg[WDOG_MOD][MM_MATCH];  // see R9
    end
  end

  // ----------------------------------------------------------------
  // event status, clear and enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_status <= ST_RESET;
    end else if (reg_wr && reg_addr == OFF_IRQ_CLEAR) begin
      irq_status <= (irq_status & ~reg_wdata[ST_W-1:0]) | {wrap, ev_vec};
    end else begin
      irq_status <= irq_status | {wrap, ev_vec};
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_enable <= ST_RESET;
    end else if (reg_wr && reg_addr == OFF_IRQ_ENABLE) begin
      irq_enable <= reg_wdata[ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      intr <= 1'b0;
    end else begin
      intr <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cap_rd [NMOD];
  generate
    for (gi = 0; gi < NMOD; gi++) begin : g_rd
      assign cap_rd[gi] = ch[gi].cap_val;
    end
  endgenerate

  always_comb begin
    next_rdata = REG_RESET;
    if (reg_addr == OFF_CONTROL) begin
      // bit 5 reads as zero
      next_rdata = {rollover_flag, run_control, 1'b0,
                    module_event_flag};  // see R18
    end else if (reg_addr == OFF_MODE_CTL) begin
      next_rdata = counter_mode_reg;
    end else if (reg_addr == OFF_IRQ_STATUS) begin
      next_rdata = {2'b00, irq_status};
    end else if (reg_addr == OFF_IRQ_ENABLE) begin
      next_rdata = {2'b00, irq_enable};
    end
    for (int i = 0; i < NMOD; i++) begin
      if (reg_addr == OFF_MODULE_MODE + ADDR_W'(i)) begin
        next_rdata = {1'b0, module_mode_reg[i]};
      end
      if (reg_addr == OFF_CAP_LO + ADDR_W'(i)) begin
        next_rdata = cap_rd[i][REG_W-1:0];
      end
      if (reg_addr == OFF_CAP_HI + ADDR_W'(i)) begin
        next_rdata = cap_rd[i][CNT_W-1:REG_W];
      end
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= REG_RESET;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= REG_RESET;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_b);

  a_rollover_sets: assert property (wrap |=> rollover_flag)  // see R1
    else $error("wrap did not set rollover flag");
  a_rollover_irq: assert property (  // see R2
    (rollover_flag && !counter_mode_reg[CM_ROLL_IRQ]
     && !(|(module_event_flag & irq_en_vec))) |=> !irq_req)
    else $error("rollover requested irq while disabled");
  a_rollover_sticky: assert property (  // see R3
    (rollover_flag && !ctl_wr) |=> rollover_flag)
    else $error("rollover flag cleared by hardware");
  a_rollover_sw_set: assert property (  // see R3
    (ctl_wr && reg_wdata[CTL_ROLLOVER]) |=> rollover_flag)
    else $error("software write did not set rollover flag");
  a_counter_halts: assert property (  // see R4
    !run_control |=> $stable(count))
    else $error("counter moved while halted");
  a_counter_steps: assert property (  // see R4
    count_adv |=> (count == $past(count) + 16'h0001))
    else $error("counter did not step on an advancing tick");
  a_event_sets_flag: assert property (  // see R5
    (|ev_vec) |=> ((module_event_flag & $past(ev_vec))
                   == $past(ev_vec)))
    else $error("module event did not set flag");
  a_flags_sticky: assert property (  // see R6
    !ctl_wr |=> ((module_event_flag & $past(module_event_flag))
                 == $past(module_event_flag)))
    else $error("module flag cleared by hardware");
  a_reset_zero: assert property (  // see R7
    $rose(rst_sync_b) |-> (!rollover_flag && !run_control
                           && module_event_flag == 5'h00))
    else $error("control register not zero after reset");
  a_wdog_gated: assert property (  // see R9
    watchdog_reset |-> $past(counter_mode_reg[CM_WDOG]))
    else $error("watchdog pulse while watchdog disabled");
  a_module_irq: assert property (  // see R10
    (|(module_event_flag & irq_en_vec)) |=> irq_req)
    else $error("enabled module flag did not raise irq request");
  a_irq_or: assert property (  // see R16
    next_irq_req |=> irq_req [*1] ##1 1'b1)
    else $error("enabled flag did not raise irq request");
  a_wrap_status: assert property (  // see R1
    wrap |=> irq_status[ST_ROLL])
    else $error("wrap did not set rollover status bit");
  a_read_bit5: assert property (  // see R18
    (reg_rd && reg_addr == OFF_CONTROL) |=> !reg_rdata[5])
    else $error("reserved control bit read as one");

  c_rollover: cover property (wrap ##2 irq_req);
  c_capture_event: cover property ((|ev_vec) ##2 irq_req);
  c_watchdog: cover property (watchdog_reset);
endmodule

// [cacf_pin_model.sv]
/*
  model of the board side of the five module pins.
  assumes weak pull-ups, so an undriven pin reads high.
*/
`timescale 1ns/10ps
module cacf_pin_model (
  // pin lines of the block
  input  wire logic [cacf_pkg::NMOD-1:0] pin_out,
  input  wire logic [cacf_pkg::NMOD-1:0] pin_oe,
  // level seen by the block
  output logic      [cacf_pkg::NMOD-1:0] pin_in
);
  import cacf_pkg::*;
  // ------------------------------------------------------------
  // wire level
  // ------------------------------------------------------------
  logic [NMOD-1:0] ext = '1;
  // the block wins while it drives, else the pull-up or our driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  task automatic set_pin(input int i, input logic v);
    ext[i] <= v;
  endtask
endmodule

// [counter_array_control_flags_bench.sv]
/*
  self-checking bench of the counter array control block.
  assumes one 125 MHz clock and the pin model for the module pins.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module counter_array_control_flags_bench;
  import cacf_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic            core_clk, rst_b, reg_wr, reg_rd, count_tick;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, d;
  logic [NMOD-1:0] pin_in, pin_out, pin_oe;
  logic            irq_req, intr, watchdog_reset, run;
  logic [15:0]     ec, cmp;
  int              errors, samples_checked, wd, r;
  integer          seed;
  cacf_top cacf_top_i (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_tick(count_tick),
    .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
    .module_io_pin_oe(pin_oe), .irq_req(irq_req), .intr(intr),
    .watchdog_reset(watchdog_reset));
  cacf_pin_model cacf_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (watchdog_reset === 1'b1) wd++;
  // ------------------------------------------------------------
  // bus tasks and expectations
  // ------------------------------------------------------------
  // bit 7 of a mode register is reserved and reads zero
  function automatic logic [7:0] mode_rb(input logic [7:0] v);
    return v & 8'h7F;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == OFF_CONTROL) run = v[CTL_RUN];
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    `CHK("rdata", e, reg_rdata)
  endtask
  // ticks are only counted by the model while run control is set
  task automatic ticks(input int n);
    @(posedge core_clk) count_tick <= 1'b1;
    repeat (n - 1) @(posedge core_clk);
    @(posedge core_clk) count_tick <= 1'b0;
    if (run) ec = ec + n[15:0];
  endtask
  task automatic capchk(input int m);
    repeat (6) @(posedge core_clk);
    rdchk(OFF_CAP_LO + m[7:0], ec[7:0]);
    rdchk(OFF_CAP_HI + m[7:0], ec[15:8]);
  endtask
  task automatic conclude();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(8 * 90000);
    errors++;
    conclude();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 32'h03C04C24;
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; count_tick = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; run = 1'b0; ec = 16'h0000;
    errors = 0; samples_checked = 0; wd = 0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(OFF_CONTROL, 8'h00);
    rdchk(8'hD7, 8'h00);
    for (int m = 0; m < NMOD; m++) begin
      d = 8'($random(seed));
      wr(OFF_MODULE_MODE + m[7:0], d);
      rdchk(OFF_MODULE_MODE + m[7:0], mode_rb(d));
      wr(OFF_MODULE_MODE + m[7:0], 8'h00);
    end
    // stray events of the random modes are wiped first
    wr(OFF_IRQ_CLEAR, 8'h3F);
    wr(OFF_CONTROL, 8'h00);
    ticks(5);
    wr(OFF_MODULE_MODE + 8'h01, 8'h20);
    cacf_pin_model_i.set_pin(1, 1'b0);
    repeat (6) @(posedge core_clk);
    cacf_pin_model_i.set_pin(1, 1'b1);
    capchk(1);
    rdchk(OFF_CONTROL, 8'h02);
    wr(OFF_CONTROL, 8'h40);
    r = 1 + {$random(seed)} % 20;
    ticks(r);
    wr(OFF_MODULE_MODE + 8'h01, 8'h10);
    cacf_pin_model_i.set_pin(1, 1'b0);
    capchk(1);
    rdchk(OFF_CONTROL, 8'h42);
    wr(OFF_MODULE_MODE + 8'h01, 8'h30);
    ticks(3);
    cacf_pin_model_i.set_pin(1, 1'b1);
    capchk(1);
    wr(OFF_CONTROL, 8'h40);
    wr(OFF_MODULE_MODE + 8'h01, 8'h00);
    cmp = ec + 16'd5;
    wr(OFF_CAP_LO, cmp[7:0]);
    wr(OFF_CAP_HI, cmp[15:8]);
    wr(OFF_MODULE_MODE, 8'h4D);
    repeat (3) @(posedge core_clk);
    d[0] = pin_out[0];
    `CHK("oe0", 1'b1, pin_oe[0])
    ticks(6);
    repeat (4) @(posedge core_clk);
    `CHK("pin0", ~d[0], pin_out[0])
    `CHK("irq", 1'b1, irq_req)
    repeat (20) @(posedge core_clk);
    rdchk(OFF_CONTROL, 8'h41);
    rdchk(OFF_IRQ_STATUS, 8'h03);
    wr(OFF_IRQ_ENABLE, 8'h01);
    repeat (2) @(posedge core_clk);
    `CHK("intr", 1'b1, intr)
    wr(OFF_IRQ_ENABLE, 8'h00);
    repeat (2) @(posedge core_clk);
    `CHK("intr masked", 1'b0, intr)
    wr(OFF_IRQ_ENABLE, 8'h01);
    wr(OFF_IRQ_CLEAR, 8'h01);
    rdchk(OFF_IRQ_STATUS, 8'h02);
    `CHK("intr cleared", 1'b0, intr)
    wr(OFF_CONTROL, 8'h40);
    repeat (3) @(posedge core_clk);
    `CHK("irq off", 1'b0, irq_req)
    wr(OFF_MODULE_MODE, 8'h00);
    wr(OFF_MODULE_MODE + 8'h04, 8'h48);
    wr(OFF_CAP_LO + 8'h04, 8'h34);
    wr(OFF_CAP_HI + 8'h04, 8'h12);
    wr(OFF_MODE_CTL, 8'h41);
    ticks(32'h10000 - int'(ec));
    repeat (4) @(posedge core_clk);
    rdchk(OFF_CONTROL, 8'hD0);
    `CHK("irq roll", 1'b1, irq_req)
    `CHK("wdog", 1, wd)
    wr(OFF_CONTROL, 8'h40);
    rdchk(OFF_CONTROL, 8'h40);
    `CHK("irq roll off", 1'b0, irq_req)
    wr(OFF_CONTROL, 8'hC0);
    rdchk(OFF_CONTROL, 8'hC0);
    `CHK("irq sw", 1'b1, irq_req)
    wr(OFF_MODE_CTL, 8'h40);
    repeat (3) @(posedge core_clk);
    `CHK("irq gated", 1'b0, irq_req)
    wr(OFF_MODULE_MODE + 8'h02, 8'h42);
    wr(OFF_CAP_LO + 8'h02, 8'h80);
    ticks(1 + {$random(seed)} % 255);
    repeat (3) @(posedge core_clk);
    `CHK("oe2", 1'b1, pin_oe[2])
    `CHK("pwm2", ec[7:0] >= 8'h80, pin_out[2])
    conclude();
  end
endmodule
